// ---- verif/acm_host_model.sv ----
// Host model that reaches the control registers over the strobe bus.
module acm_host_model
(
	input wire logic clock_i,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i,
	output logic wr_o,
	output logic rd_o,
	output logic ptr_rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic lock_open_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import acm_pkg::*;

	initial
	begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		ptr_rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
		lock_open_o = 1'b0;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		#1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge clock_i);
		#1;
		wr_o = 1'b0;
		// Released lines do not keep the last value.
		addr_o = ~a;
		wdata_o = ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic p, output logic [7:0] d);
		int n;
		@(posedge clock_i);
		#1;
		addr_o = a;
		ptr_rd_o = p;
		rd_o = 1'b1;
		@(posedge clock_i);
		#1;
		rd_o = 1'b0;
		ptr_rd_o = 1'b0;
		addr_o = ~a;
		n = 0;
		while (rvalid_i !== 1'b1 && n < 4)
		begin
			@(posedge clock_i);
			#1;
			n++;
		end
		d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
	endtask : rd

	task automatic set_lock(input logic v);
		lock_open_o = v;
	endtask : set_lock

	task automatic select(input logic [4:0] code);
		lock_open_o = 1'b1;
		wr(ADDR_SELECTOR, {3'h0, code});
	endtask : select

endmodule : acm_host_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the accelerometer control registers.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import acm_pkg::*;

	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic wr, rd, prd, lock, rvalid, av, sv, ready, fv, tw, ev;
	logic tw_b;
	logic [7:0] addr, wdata, rdata, frame;
	logic [7:0] pval;
	logic [10:0] smp;
	acm_axes_t acc;
	acm_op_cfg_t op;
	int failures = 0;
	int n_tests = 0;
	logic [4:0] codes [6] = '{SEL_TWO_WIRE, SEL_MOTION_CTRL, SEL_Y_TH,
		SEL_X_TH, SEL_Z_TH, SEL_OUT_CTRL};
	logic [7:0] rst_val [6] = '{TWO_WIRE_ON_A, {2'h0, MCTRL_RESET},
		TH_RESET_A, TH_RESET_A, TH_RESET_A, OUT_CTRL_RESET};

	always #2 clock = ~clock;

	acm_host_model acm_host_model_i
	(
		.clock_i(clock), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr),
		.rd_o(rd), .ptr_rd_o(prd), .addr_o(addr), .wdata_o(wdata),
		.lock_open_o(lock)
	);

	acm_regs acm_regs_i
	(
		.clock_i(clock), .rstn_i(rstn), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_ptr_rd_i(prd), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .lock_open_i(lock),
		.accel_valid_i(av), .accel_i(acc), .sample_valid_i(sv),
		.sample_i(smp), .sample_ready_o(ready), .frame_o(frame),
		.frame_valid_o(fv), .op_cfg_o(op), .two_wire_enabled_o(tw),
		.motion_event_o(ev)
	);

	// A second copy in the other variant checks its own disable codes.
	acm_regs #(.VARIANT_B(1'b1), .TH_RESET(TH_RESET_B)) acm_regs_b_i
	(
		.clock_i(clock), .rstn_i(rstn), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_ptr_rd_i(prd), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_rdata_o(), .reg_rvalid_o(), .lock_open_i(lock),
		.accel_valid_i(av), .accel_i(acc), .sample_valid_i(sv),
		.sample_i(smp), .sample_ready_o(), .frame_o(), .frame_valid_o(),
		.op_cfg_o(), .two_wire_enabled_o(tw_b), .motion_event_o()
	);

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic w(input logic [7:0] a, input logic [7:0] d);
		acm_host_model_i.wr(a, d);
	endtask : w

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		acm_host_model_i.rd(a, 1'b0, d);
		check(d, exp);
	endtask : rdchk

	task automatic send(input logic [10:0] s, input logic two);
		int n;
		n = 0;
		smp = s;
		sv = 1'b1;
		while (ready !== 1'b1 && n < 8)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		@(posedge clock);
		#1;
		sv = 1'b0;
		smp = ~s;
		check(fv, 1'b1);
		check(frame, s[10:3]);
		if (two)
		begin
			@(posedge clock);
			#1;
			check(fv, 1'b1);
			check(frame, {s[2:0], 5'h00});
		end
		@(posedge clock);
		#1;
		check(fv, 1'b0);
	endtask : send

	task automatic shake(input logic [23:0] a, input logic e, input logic [7:0] st);
		acc = a;
		av = 1'b1;
		@(posedge clock);
		#1;
		av = 1'b0;
		acc = ~a;
		check(ev, e);
		if (st !== 8'hff)
			rdchk(ADDR_INT_STATUS, st);
	endtask : shake

	initial
	begin
		#50000;
		failures++;
		finish_test();
	end

	initial
	begin
		av = 1'b0;
		sv = 1'b0;
		smp = '0;
		acc = '0;
		repeat (12) @(posedge clock);
		#1;
		rstn = 1'b1;
		rdchk(ADDR_OPERATION, OP_RESET);
		check(op, 8'h00);
		check(tw, 1'b1);
		check(tw_b, 1'b1);
		rdchk(ADDR_STATUS, 8'h00);
		w(ADDR_SELECTOR, 8'h03);
		rdchk(ADDR_SELECTOR, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			acm_host_model_i.select(codes[i]);
			rdchk(ADDR_INDIRECT_DATA, rst_val[i]);
		end
		rdchk(ADDR_STATUS, 8'h20);
		$display("test reset_and_lock done");
		acm_host_model_i.select(5'h07);
		w(ADDR_INDIRECT_DATA, 8'h55);
		rdchk(ADDR_INDIRECT_DATA, 8'h00);
		w(ADDR_SELECTOR, 8'he4);
		rdchk(ADDR_SELECTOR, 8'h04);
		w(ADDR_INDIRECT_DATA, 8'h20);
		rdchk(ADDR_INDIRECT_DATA, 8'h20);
		acm_host_model_i.select(SEL_Y_TH);
		rdchk(ADDR_INDIRECT_DATA, TH_RESET_A);
		acm_host_model_i.select(SEL_TWO_WIRE);
		w(ADDR_INDIRECT_DATA, TWO_WIRE_OFF_A);
		@(posedge clock);
		#1;
		check(tw, 1'b0);
		check(tw_b, 1'b1);
		w(ADDR_INDIRECT_DATA, TWO_WIRE_OFF_B);
		check(tw_b, 1'b0);
		check(tw, 1'b1);
		w(ADDR_INDIRECT_DATA, TWO_WIRE_ON_A);
		@(posedge clock);
		#1;
		check(tw, 1'b1);
		check(tw_b, 1'b1);
		$display("test indirect done");
		for (int m = 0; m < 4; m++)
		begin
			w(ADDR_OPERATION, 8'(m));
			check(op, 8'(m));
		end
		w(ADDR_OPERATION, 8'h07);
		check(op, 8'h03);
		w(ADDR_OPERATION, 8'hfb);
		check(op, 8'h3b);
		rdchk(ADDR_OPERATION, 8'hd3);
		w(ADDR_READ_POINTER, ADDR_OPERATION);
		rdchk(ADDR_READ_POINTER, 8'h00);
		acm_host_model_i.rd(ADDR_STATUS, 1'b1, pval);
		check(pval, 8'hd3);
		w(ADDR_READ_POINTER, ADDR_SELECTOR);
		acm_host_model_i.rd(ADDR_STATUS, 1'b1, pval);
		check(pval, {3'h0, SEL_TWO_WIRE});
		$display("test operation done");
		w(ADDR_OPERATION, 8'h00);
		sv = 1'b1;
		repeat (3) @(posedge clock);
		#1;
		check(ready, 1'b0);
		sv = 1'b0;
		w(ADDR_OPERATION, 8'h80);
		send(11'h5a5, 1'b1);
		send(11'h3c2, 1'b1);
		w(ADDR_OPERATION, 8'hc0);
		send(11'h5a5, 1'b0);
		$display("test framer done");
		w(ADDR_OPERATION, 8'h03);
		shake({8'h00, 8'h20, 8'h00}, 1'b0, 8'h00);
		shake({8'h00, 8'h21, 8'h00}, 1'b1, 8'h02);
		shake({8'h00, 8'h00, 8'hef}, 1'b1, 8'h04);
		shake({8'he0, 8'h00, 8'h00}, 1'b1, 8'h01);
		acm_host_model_i.select(SEL_MOTION_CTRL);
		w(ADDR_INDIRECT_DATA, 8'h18);
		shake({8'h00, 8'h21, 8'h00}, 1'b0, 8'hff);
		shake({8'h00, 8'h21, 8'h11}, 1'b1, 8'h06);
		// A trigger in the clearing read cycle must survive the clear.
		acc = {8'h00, 8'h21, 8'h11};
		av = 1'b1;
		rdchk(ADDR_INT_STATUS, 8'h06);
		av = 1'b0;
		rdchk(ADDR_INT_STATUS, 8'h06);
		w(ADDR_OPERATION, 8'h00);
		shake({8'h7f, 8'h7f, 8'h7f}, 1'b0, 8'h00);
		$display("test motion done");
		finish_test();
	end

endmodule : tb_top

// ---- verilog/acm_motion_detect.sv ----
// Motion detector: per-axis threshold compare and AND/OR trigger combination.
module acm_motion_detect
(
	input wire logic enable_i,
	input wire logic accel_valid_i,
	input wire acm_pkg::acm_axes_t accel_i,
	input wire acm_pkg::acm_axes_t thresholds_i,
	input wire acm_pkg::acm_motion_ctrl_t ctrl_i,
	output logic event_o,
	output logic [2:0] channels_o
);
	import acm_pkg::*;

	logic [2:0] trig;

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : axis
			logic [8:0] magnitude;
			// Two's complement samples are folded to a 9-bit magnitude.
			assign magnitude = accel_i[g][7] ?
				9'(~accel_i[g]) + 9'h001 : {1'b0, accel_i[g]}; // R18
			assign trig[g] = enable_i && accel_valid_i &&
				(magnitude > {1'b0, thresholds_i[g]}); // R17 R18
		end
	endgenerate

	logic any_enabled;
	logic all_required;
	assign any_enabled = |(trig & ctrl_i.enable_zxy); // R14
	assign all_required = (ctrl_i.require_zxy != 3'h0) &&
		((trig & ctrl_i.require_zxy) == ctrl_i.require_zxy); // R13
	assign event_o = any_enabled || all_required;
	assign channels_o = {trig[AXIS_Y], trig[AXIS_X], trig[AXIS_Z]}; // R20

endmodule : acm_motion_detect

// ---- verilog/acm_pkg.sv ----
// Constants, codes and carrier types of the accelerometer control registers.
package acm_pkg;

	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_OPERATION = 8'h14;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h16;
	localparam logic [7:0] ADDR_READ_POINTER = 8'h17;
	localparam logic [7:0] ADDR_SELECTOR = 8'h18;
	localparam logic [7:0] ADDR_INDIRECT_DATA = 8'h19;

	localparam int OP_BUF_EN_BIT = 7;
	localparam int OP_SHORT_FMT_BIT = 6;
	localparam int OP_FREEFALL_DETECT_ENABLE_BIT = 4;
	localparam int STATUS_LOCK_BIT = 5;
	localparam int SEL_W = 5;
	localparam int MCTRL_REQ_LSB = 3;

	localparam logic [SEL_W-1:0] SEL_TWO_WIRE = 5'h01;
	localparam logic [SEL_W-1:0] SEL_MOTION_CTRL = 5'h02;
	localparam logic [SEL_W-1:0] SEL_Y_TH = 5'h03;
	localparam logic [SEL_W-1:0] SEL_X_TH = 5'h04;
	localparam logic [SEL_W-1:0] SEL_Z_TH = 5'h05;
	localparam logic [SEL_W-1:0] SEL_OUT_CTRL = 5'h0b;

	localparam logic [7:0] OP_RESET = 8'h00;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
	localparam logic [5:0] MCTRL_RESET = 6'h07;
	localparam logic [7:0] TWO_WIRE_ON_A = 8'h10;
	localparam logic [7:0] TWO_WIRE_OFF_A = 8'h00;
	localparam logic [7:0] TWO_WIRE_ON_B = 8'h50;
	localparam logic [7:0] TWO_WIRE_OFF_B = 8'h40;
	localparam logic [7:0] TH_RESET_A = 8'h10;
	localparam logic [7:0] TH_RESET_B = 8'h08;
	localparam logic [7:0] OUT_CTRL_RESET = 8'h00;

	// Axis slots; the order matches the trigger control bits.
	localparam int AXIS_Y = 0;
	localparam int AXIS_X = 1;
	localparam int AXIS_Z = 2;

	typedef enum logic [2:0]
	{
		MODE_NORMAL = 3'h0,
		MODE_OPT2 = 3'h1,
		MODE_OPT1 = 3'h2,
		MODE_MOTION = 3'h3
	} acm_mode_t;

	typedef enum logic [1:0]
	{
		FMT_IDLE = 2'h0,
		FMT_LSB = 2'h1
	} acm_fmt_state_t;

	typedef struct packed
	{
		logic buffer_enable;
		logic short_sample_format;
		logic freefall_detect_enable;
		acm_mode_t mode;
	} acm_op_cfg_t;

	typedef struct packed
	{
		logic [2:0] require_zxy;
		logic [2:0] enable_zxy;
	} acm_motion_ctrl_t;

	typedef logic [2:0][7:0] acm_axes_t;

endpackage : acm_pkg

// ---- verilog/acm_regs.sv ----
// Operation mode, read pointer and indirect control registers of the sensor.
// Overview of operation
// R1 - Bit 7 enables ring buffer, resets 0
// R2 - Bit 6 set: one byte per sample
// R3 - Bit 6 clear: two bytes per sample
// R4 - Unused bits of long frames are zero
// R5 - Bit 4 enables free-fall detection, resets 0
// R6 - Bits 2:0 select mode, others reserved
// R7 - Pointer register selects target of two-wire reads
// R8 - Selector writes accepted only while unlocked
// R9 - Data port routes to selected indirect register
// R10 - Selector codes decode to indirect registers
// R11 - Variant A: reset 10h, 00h disables
// R12 - Variant B: reset 50h, 40h disables
// R13 - Require bits AND the Z, X, Y triggers
// R14 - Enable bits OR the Z, X, Y triggers
// R15 - Y threshold register, variant reset value
// R16 - X threshold register, variant reset value
// R17 - Z threshold reached through code 00101
// R18 - Thresholds compare against absolute acceleration
// R19 - Status bit 5 shows lock open
// R20 - Status bits 2:0 show fired channels
// R21 - Reserved codes and bits ignored, read zero
// R22 - Data port is one direct 8-bit register
module acm_regs
#(
	parameter bit VARIANT_B = 1'b0,
	parameter logic [7:0] TH_RESET = acm_pkg::TH_RESET_A,
	parameter int SAMPLE_W = 11
)
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_ptr_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic lock_open_i,
	input wire logic accel_valid_i,
	input wire acm_pkg::acm_axes_t accel_i,
	input wire logic sample_valid_i,
	input wire logic [SAMPLE_W-1:0] sample_i,
	output logic sample_ready_o,
	output logic [7:0] frame_o,
	output logic frame_valid_o,
	output acm_pkg::acm_op_cfg_t op_cfg_o,
	output logic two_wire_enabled_o,
	output logic motion_event_o
);
	import acm_pkg::*;

	localparam int PAD_W = 16 - SAMPLE_W;
	localparam logic [7:0] TW_ON = VARIANT_B ? TWO_WIRE_ON_B : TWO_WIRE_ON_A;
	localparam logic [7:0] TW_OFF = VARIANT_B ? TWO_WIRE_OFF_B : TWO_WIRE_OFF_A;

	function automatic logic legal_mode(input logic [2:0] code);
		legal_mode = (code == MODE_NORMAL) || (code == MODE_OPT1) ||
			(code == MODE_OPT2) || (code == MODE_MOTION);
	endfunction : legal_mode

	function automatic logic legal_sel(input logic [SEL_W-1:0] code);
		legal_sel = (code == SEL_TWO_WIRE) || (code == SEL_MOTION_CTRL) ||
			(code == SEL_Y_TH) || (code == SEL_X_TH) ||
			(code == SEL_Z_TH) || (code == SEL_OUT_CTRL);
	endfunction : legal_sel

	acm_op_cfg_t op_reg, op_next;
	logic [7:0] ptr_reg, ptr_next;
	logic [SEL_W-1:0] sel_reg, sel_next;
	logic [7:0] twd_reg, twd_next;
	logic tw_en_reg, tw_en_next;
	acm_motion_ctrl_t mctrl_reg, mctrl_next;
	acm_axes_t th_reg, th_next;
	logic [7:0] outc_reg, outc_next;
	logic [2:0] ints_reg, ints_next;
	logic mevt_reg, mevt_next;
	logic md_event;
	logic [2:0] md_channels;
	logic [7:0] rd_addr;
	logic [7:0] indirect_rd;
	logic [7:0] direct_rd;
	logic wr_op, wr_sel, wr_data, wr_ptr;

	assign wr_op = reg_wr_i && (reg_addr_i == ADDR_OPERATION);
	assign wr_sel = reg_wr_i && (reg_addr_i == ADDR_SELECTOR);
	assign wr_data = reg_wr_i && (reg_addr_i == ADDR_INDIRECT_DATA);
	assign wr_ptr = reg_wr_i && (reg_addr_i == ADDR_READ_POINTER);
	// Two-wire reads take their address from the pointer.
	assign rd_addr = reg_ptr_rd_i ? ptr_reg : reg_addr_i; // R7

	acm_motion_detect u_motion
	(
		.enable_i(op_reg.mode == MODE_MOTION),
		.accel_valid_i(accel_valid_i),
		.accel_i(accel_i),
		.thresholds_i(th_reg),
		.ctrl_i(mctrl_reg),
		.event_o(md_event),
		.channels_o(md_channels)
	);

	always_comb
	begin
		op_next = op_reg;
		ptr_next = ptr_reg;
		sel_next = sel_reg;
		twd_next = twd_reg;
		mctrl_next = mctrl_reg;
		th_next = th_reg;
		outc_next = outc_reg;
		ints_next = ints_reg;
		mevt_next = md_event;
		if (wr_op)
		begin
			op_next.buffer_enable = reg_wdata_i[OP_BUF_EN_BIT]; // R1
			op_next.short_sample_format = reg_wdata_i[OP_SHORT_FMT_BIT];
			op_next.freefall_detect_enable = reg_wdata_i[OP_FREEFALL_DETECT_ENABLE_BIT]; // R5
			if (legal_mode(reg_wdata_i[2:0])) // R6 R21
			begin
				op_next.mode = acm_mode_t'(reg_wdata_i[2:0]);
			end
		end
		if (wr_ptr)
		begin
			ptr_next = reg_wdata_i; // R7
		end
		if (wr_sel && lock_open_i) // R8
		begin
			sel_next = reg_wdata_i[SEL_W-1:0]; // R21
		end
		if (wr_data) // R9 R22
		begin
			case (sel_reg) // R10 R21
				SEL_TWO_WIRE: twd_next = reg_wdata_i; // R11 R12
				SEL_MOTION_CTRL: mctrl_next = reg_wdata_i[5:0]; // R13 R14
				SEL_Y_TH: th_next[AXIS_Y] = reg_wdata_i; // R15
				SEL_X_TH: th_next[AXIS_X] = reg_wdata_i; // R16
				SEL_Z_TH: th_next[AXIS_Z] = reg_wdata_i; // R17
				SEL_OUT_CTRL: outc_next = reg_wdata_i;
				default: outc_next = outc_reg;
			endcase
		end
		// Reading the status clears it, but a new trigger in that cycle wins.
		if (reg_rd_i && (rd_addr == ADDR_INT_STATUS))
		begin
			ints_next = 3'h0;
		end
		if (md_event)
		begin
			ints_next = ints_next | md_channels; // R20
		end
		tw_en_next = (twd_next != TW_OFF); // R11 R12
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			op_reg.buffer_enable <= OP_RESET[OP_BUF_EN_BIT]; // R1
			op_reg.short_sample_format <= OP_RESET[OP_SHORT_FMT_BIT];
			op_reg.freefall_detect_enable <= OP_RESET[OP_FREEFALL_DETECT_ENABLE_BIT]; // R5
			op_reg.mode <= acm_mode_t'(OP_RESET[2:0]);
			ptr_reg <= PTR_RESET;
			sel_reg <= SEL_RESET;
			twd_reg <= TW_ON; // R11 R12
			tw_en_reg <= 1'b1;
			mctrl_reg <= MCTRL_RESET; // R13 R14
			th_reg <= {TH_RESET, TH_RESET, TH_RESET}; // R15 R16
			outc_reg <= OUT_CTRL_RESET;
			ints_reg <= 3'h0;
			mevt_reg <= 1'b0;
		end
		else
		begin
			op_reg <= op_next;
			ptr_reg <= ptr_next;
			sel_reg <= sel_next;
			twd_reg <= twd_next;
			tw_en_reg <= tw_en_next;
			mctrl_reg <= mctrl_next;
			th_reg <= th_next;
			outc_reg <= outc_next;
			ints_reg <= ints_next;
			mevt_reg <= mevt_next;
		end
	end

	assign op_cfg_o = op_reg;
	assign two_wire_enabled_o = tw_en_reg;
	assign motion_event_o = mevt_reg;

	// Read path.
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;

	always_comb
	begin
		case (sel_reg) // R9 R10
			SEL_TWO_WIRE: indirect_rd = twd_reg;
			SEL_MOTION_CTRL: indirect_rd = {2'h0, mctrl_reg};
			SEL_Y_TH: indirect_rd = th_reg[AXIS_Y];
			SEL_X_TH: indirect_rd = th_reg[AXIS_X];
			SEL_Z_TH: indirect_rd = th_reg[AXIS_Z];
			SEL_OUT_CTRL: indirect_rd = outc_reg;
			default: indirect_rd = 8'h00; // R21
		endcase
		direct_rd = 8'h00;
		case (rd_addr)
			ADDR_STATUS: direct_rd[STATUS_LOCK_BIT] = lock_open_i; // R19
			ADDR_OPERATION:
			begin
				direct_rd[OP_BUF_EN_BIT] = op_reg.buffer_enable;
				direct_rd[OP_SHORT_FMT_BIT] = op_reg.short_sample_format;
				direct_rd[OP_FREEFALL_DETECT_ENABLE_BIT] = op_reg.freefall_detect_enable;
				direct_rd[2:0] = op_reg.mode;
			end
			ADDR_INT_STATUS: direct_rd[2:0] = ints_reg; // R20
			ADDR_SELECTOR: direct_rd[SEL_W-1:0] = sel_reg;
			ADDR_INDIRECT_DATA: direct_rd = indirect_rd; // R22
			default: direct_rd = 8'h00;
		endcase
		rdata_next = reg_rd_i ? direct_rd : rdata_reg;
		rvalid_next = reg_rd_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;

	// Sample framer for the ring buffer output.
	acm_fmt_state_t fmt_reg, fmt_next;
	logic [7:0] frame_reg, frame_next;
	logic [7:0] lsb_reg, lsb_next;
	logic fvalid_reg, fvalid_next;
	logic ready_reg, ready_next;
	logic [15:0] wide;
	logic take;

	assign wide = {sample_i, {PAD_W{1'b0}}}; // R4
	assign take = sample_valid_i && ready_reg;

	always_comb
	begin
		fmt_next = fmt_reg;
		frame_next = frame_reg;
		lsb_next = lsb_reg;
		fvalid_next = 1'b0;
		case (fmt_reg)
			FMT_IDLE:
			begin
				if (take)
				begin
					frame_next = wide[15:8]; // R2 R3
					fvalid_next = 1'b1;
					lsb_next = wide[7:0];
					if (!op_reg.short_sample_format) // R3
					begin
						fmt_next = FMT_LSB;
					end
				end
			end
			FMT_LSB:
			begin
				frame_next = lsb_reg; // R3 R4
				fvalid_next = 1'b1;
				fmt_next = FMT_IDLE;
			end
			default: fmt_next = FMT_IDLE;
		endcase
		// A disabled buffer holds sample_ready_o low and refuses samples.
		ready_next = op_next.buffer_enable && (fmt_next == FMT_IDLE) &&
			!(take && !op_reg.short_sample_format); // R1
	end

	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			fmt_reg <= FMT_IDLE;
			frame_reg <= 8'h00;
			lsb_reg <= 8'h00;
			fvalid_reg <= 1'b0;
			ready_reg <= 1'b0;
		end
		else
		begin
			fmt_reg <= fmt_next;
			frame_reg <= frame_next;
			lsb_reg <= lsb_next;
			fvalid_reg <= fvalid_next;
			ready_reg <= ready_next;
		end
	end

	assign frame_o = frame_reg;
	assign frame_valid_o = fvalid_reg;
	assign sample_ready_o = ready_reg;

	buf_enable_write_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R1
		wr_op |=> op_cfg_o.buffer_enable == $past(reg_wdata_i[OP_BUF_EN_BIT]))
		else $error("buffer enable did not follow the write");
	short_frame_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R2
		take && op_reg.short_sample_format |=> frame_valid_o &&
		frame_o == $past(wide[15:8]) ##1 (!frame_valid_o || $past(take)))
		else $error("short format did not give one frame");
	long_frames_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R3
		take && !op_reg.short_sample_format |=> frame_valid_o
		##1 frame_valid_o && frame_o == $past(wide[7:0], 2))
		else $error("long format did not give two frames");
	lsb_pad_zero_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R4
		fmt_reg == FMT_LSB |=> frame_o[PAD_W-1:0] == '0)
		else $error("unused frame bits not zero");
	freefall_write_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R5
		wr_op |=> op_cfg_o.freefall_detect_enable ==
		$past(reg_wdata_i[OP_FREEFALL_DETECT_ENABLE_BIT]))
		else $error("free-fall enable did not follow the write");
	mode_reserved_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R6
		wr_op && !legal_mode(reg_wdata_i[2:0]) |=> $stable(op_reg.mode))
		else $error("reserved mode code was taken");
	pointer_read_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R7
		reg_rd_i && reg_ptr_rd_i && ptr_reg == ADDR_SELECTOR |=>
		reg_rvalid_o && reg_rdata_o == {3'h0, $past(sel_reg)})
		else $error("pointer read returned wrong register");
	sel_locked_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R8
		wr_sel && !lock_open_i |=> $stable(sel_reg))
		else $error("selector written while locked");
	indirect_route_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R9
		wr_data && sel_reg == SEL_X_TH |=> th_reg[AXIS_X] == $past(reg_wdata_i))
		else $error("data port write not routed to X threshold");
	reserved_read_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R21
		reg_rd_i && rd_addr == ADDR_INDIRECT_DATA && !legal_sel(sel_reg)
		|=> reg_rdata_o == 8'h00)
		else $error("reserved indirect code read nonzero");
	two_wire_off_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R11
		wr_data && sel_reg == SEL_TWO_WIRE && reg_wdata_i == TW_OFF
		|=> !two_wire_enabled_o)
		else $error("two-wire interface still enabled");
	status_set_wins_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R20
		md_event && reg_rd_i && rd_addr == ADDR_INT_STATUS |=>
		ints_reg == $past(md_channels))
		else $error("trigger lost against status clear");

endmodule : acm_regs
